// ===== rtl/scss_consts.svh
// constants for the stage command switch selector
`ifndef SCSS_CONSTS_SVH
`define SCSS_CONSTS_SVH
`define SCSS_WORD_W 8
`define SCSS_CHANNELS 112
`define SCSS_SEL_W 7
`define SCSS_ZERO_WORD 8'h00
`endif

// ===== rtl/scss_pkg.sv
// types for the stage command switch selector
`include "scss_consts.svh"
package scss_pkg;
  typedef logic [`SCSS_WORD_W-1:0] scss_word_t;
  typedef logic [`SCSS_CHANNELS-1:0] scss_chan_t;
  typedef enum logic [1:0] {SCSS_IDLE, SCSS_HELD, SCSS_FIRE} scss_state_e;
endpackage

// ===== rtl/scss_latch_bank.sv
// per-command latch bank with all-clear chain
`timescale 1ns/1ps
`include "scss_consts.svh"
module scss_latch_bank #(
  parameter int CHANNELS = `SCSS_CHANNELS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic set_pulse,
  input wire logic [CHANNELS-1:0] set_onehot,
  input wire logic clear,
  output logic [CHANNELS-1:0] latched,
  output logic all_reset
);
  logic [CHANNELS-1:0] next_latched;
  logic next_all_reset;

  always_comb begin
    next_latched = latched;
    if (clear) begin
      next_latched = '0;
    end
    if (set_pulse) begin
      next_latched = next_latched | set_onehot;
    end
    next_all_reset = ~|next_latched;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      latched <= '0;
      all_reset <= 1'b1;
    end else begin
      latched <= next_latched;
      all_reset <= next_all_reset;
    end
  end
endmodule

// ===== rtl/scss_top.sv
// stage command switch selector top
`timescale 1ns/1ps
`include "scss_consts.svh"
module scss_top
  import scss_pkg::*;
#(
  parameter int CHANNELS = `SCSS_CHANNELS
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic WORD_STROBE,
  input wire logic STAGE_ADDRESSED,
  input wire scss_pkg::scss_word_t WORD_IN,
  input wire logic FIRE_STROBE,
  input wire logic RESET_STROBE,
  input wire logic GROUND_CLEAR,
  input wire logic EMERGENCY_CMD,
  output scss_pkg::scss_word_t VERIFY_WORD,
  output logic VERIFY_VALID,
  output logic [CHANNELS-1:0] CMD_OUT,
  output logic ALL_CLEAR,
  output logic ENGINE_SHUTDOWN
);
  import scss_pkg::*;

  function automatic logic [CHANNELS-1:0] decode_word(input scss_word_t w);
    logic [CHANNELS-1:0] d;
    d = '0;
    if (int'(w) < CHANNELS) begin
      d[w[`SCSS_SEL_W-1:0]] = 1'b1;
    end
    return d;
  endfunction

  scss_state_e state;
  scss_state_e next_state;
  scss_word_t held_word;
  scss_word_t next_held_word;
  scss_word_t next_verify_word;
  logic next_verify_valid;
  logic next_shutdown;
  logic fire_pulse;
  logic [CHANNELS-1:0] latched;
  logic all_reset;

  always_comb begin
    next_state = state;
    next_held_word = held_word;
    next_verify_word = VERIFY_WORD;
    next_verify_valid = VERIFY_VALID;
    fire_pulse = 1'b0;
    case (state)
      SCSS_IDLE: begin
        if (WORD_STROBE && STAGE_ADDRESSED) begin
          next_held_word = WORD_IN;
          next_verify_word = ~WORD_IN;
          next_verify_valid = 1'b1;
          next_state = SCSS_HELD;
        end
      end
      SCSS_HELD: begin
        if (RESET_STROBE) begin
          next_verify_valid = 1'b0;
          next_state = SCSS_IDLE;
        end else if (FIRE_STROBE) begin
          fire_pulse = 1'b1;
          next_state = SCSS_FIRE;
        end else if (WORD_STROBE && STAGE_ADDRESSED) begin
          next_held_word = WORD_IN;
          next_verify_word = ~WORD_IN;
        end
      end
      SCSS_FIRE: begin
        next_verify_valid = 1'b0;
        next_state = SCSS_IDLE;
      end
      default: begin
        next_state = SCSS_IDLE;
      end
    endcase
    next_shutdown = ENGINE_SHUTDOWN | EMERGENCY_CMD;
    if (GROUND_CLEAR && !EMERGENCY_CMD) begin
      next_shutdown = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= SCSS_IDLE;
      held_word <= `SCSS_ZERO_WORD;
      VERIFY_WORD <= `SCSS_ZERO_WORD;
      VERIFY_VALID <= 1'b0;
      ENGINE_SHUTDOWN <= 1'b0;
    end else begin
      state <= next_state;
      held_word <= next_held_word;
      VERIFY_WORD <= next_verify_word;
      VERIFY_VALID <= next_verify_valid;
      ENGINE_SHUTDOWN <= next_shutdown;
    end
  end

  scss_latch_bank #(.CHANNELS(CHANNELS)) u_latches (
    .clk(CLK),
    .reset(RESET),
    .set_pulse(fire_pulse),
    .set_onehot(decode_word(held_word)),
    .clear(GROUND_CLEAR),
    .latched(latched),
    .all_reset(all_reset)
  );

  always_comb begin
    CMD_OUT = latched;
    ALL_CLEAR = all_reset;
  end
endmodule

// ===== tb/scss_top_properties.sv
// selector port assertions
`timescale 1ns/1ps
module scss_props #(parameter int CHANNELS = 112) (
  input wire logic CLK, RESET, WORD_STROBE, STAGE_ADDRESSED, FIRE_STROBE, RESET_STROBE, GROUND_CLEAR,
  input wire logic EMERGENCY_CMD, VERIFY_VALID, ALL_CLEAR, ENGINE_SHUTDOWN,
  input wire scss_pkg::scss_word_t WORD_IN, VERIFY_WORD,
  input wire logic [CHANNELS-1:0] CMD_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_word_taken: assert property (WORD_STROBE && STAGE_ADDRESSED && !VERIFY_VALID && !RESET_STROBE
    |=> VERIFY_VALID && VERIFY_WORD == ~$past(WORD_IN)) else $error("bad echo");
  a_unaddr_ignored: assert property (WORD_STROBE && !STAGE_ADDRESSED && !VERIFY_VALID
    |=> !VERIFY_VALID) else $error("foreign word taken");
  a_fire_cause: assert property ($fell(ALL_CLEAR) |-> $past(FIRE_STROBE) && $past(VERIFY_VALID))
    else $error("unfired set");
  a_one_channel: assert property ($onehot0(CMD_OUT & ~$past(CMD_OUT))) else $error("many set");
  a_latch_hold: assert property (!GROUND_CLEAR |=> (CMD_OUT & $past(CMD_OUT)) == $past(CMD_OUT))
    else $error("latch lost");
  a_ground_clear: assert property (GROUND_CLEAR && !FIRE_STROBE |=> CMD_OUT == '0) else $error("no clear");
  a_all_clear: assert property (ALL_CLEAR == (CMD_OUT == '0)) else $error("bad all clear");
  a_shutdown: assert property (EMERGENCY_CMD || ENGINE_SHUTDOWN && !GROUND_CLEAR |=> ENGINE_SHUTDOWN)
    else $error("no shutdown");
endmodule
bind scss_top scss_props #(.CHANNELS(CHANNELS)) u_props(.*);

// ===== tb/scss_fc_model.sv
// flight computer model
`timescale 1ns/1ps
module scss_fc_model (
  input wire logic CLK,
  input wire scss_pkg::scss_word_t VERIFY_WORD,
  input wire logic VERIFY_VALID,
  output logic WORD_STROBE, STAGE_ADDRESSED, FIRE_STROBE, RESET_STROBE,
  output scss_pkg::scss_word_t WORD_IN
);
  initial {WORD_STROBE, STAGE_ADDRESSED, FIRE_STROBE, RESET_STROBE, WORD_IN} = 12'h000;
  // send, compare echo, then fire or discard
  task automatic cmd(input scss_pkg::scss_word_t w, input bit flip, input bit adr, output bit ok);
    ok = 0;
    @(negedge CLK);
    {WORD_STROBE, STAGE_ADDRESSED, WORD_IN} <= {1'b1, adr, w ^ {7'h00, flip}};
    @(negedge CLK);
    WORD_STROBE <= 1'b0;
    WORD_IN <= ~WORD_IN;
    for (int n = 0; n < 4 && VERIFY_VALID !== 1'b1; n++) @(negedge CLK);
    if (VERIFY_VALID !== 1'b1) return;
    ok = VERIFY_WORD === ~w;
    {FIRE_STROBE, RESET_STROBE} <= {ok, !ok};
    @(negedge CLK);
    {FIRE_STROBE, RESET_STROBE} <= 2'b00;
  endtask
endmodule

// ===== tb/testbench.sv
// selector bench
`timescale 1ns/1ps
module testbench;
  import scss_pkg::*;
  logic CLK = 0, RESET = 1, GROUND_CLEAR = 0, EMERGENCY_CMD = 0;
  logic WORD_STROBE, STAGE_ADDRESSED, FIRE_STROBE, RESET_STROBE, VERIFY_VALID, ALL_CLEAR, ENGINE_SHUTDOWN;
  scss_word_t WORD_IN, VERIFY_WORD, w;
  scss_chan_t CMD_OUT, e = '0;
  int err_total = 0, checked = 0;
  bit ok;
  scss_top u_dut(.*);
  scss_fc_model u_fc(.*);
  initial forever #4 CLK = ~CLK;
  task automatic chk(string n, logic [111:0] x, logic [111:0] g);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic results;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic scss_chan_t fired(scss_chan_t c, scss_word_t v);
    return v < 8'h70 ? c | 112'h1 << v : c;
  endfunction
  initial begin
    void'($urandom(32'h781387C7));
    repeat (16) @(negedge CLK);
    RESET = 0;
    for (int i = 0; i < 24; i++) begin
      w = 8'(i == 1 ? 111 : i == 2 ? 112 : i == 3 ? 255 : i == 4 ? 0 : $urandom);
      u_fc.cmd(w, i[0], i != 5, ok);
      chk("ok", 112'(i != 5 && !i[0]), 112'(ok));
      if (i[0] && i != 5) u_fc.cmd(w, 0, 1, ok);
      if (ok) e = fired(e, w);
      chk("cmd", e, CMD_OUT);
      chk("clr", 112'(e == 0), 112'(ALL_CLEAR));
      if (i == 12) begin
        {EMERGENCY_CMD, GROUND_CLEAR} = 2'b11;
        @(negedge CLK);
        EMERGENCY_CMD = 0;
        e = '0;
        chk("sd", 1, ENGINE_SHUTDOWN);
        chk("cmd", e, CMD_OUT);
        @(negedge CLK);
        GROUND_CLEAR = 0;
        chk("sd", 0, ENGINE_SHUTDOWN);
      end
    end
    results();
  end
endmodule
